//--- design/sbdsk_core.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// subtract-with-borrow and decrement-skip execution unit, apb reachable
// ---------------------------------------------------------------------

// Function
// (RULE1) subtract memory and inverse borrow from work_register
// (RULE2) borrow flag 0 if negative, else 1
// (RULE3) subtracts update the four status flags only
// (RULE4) memory-destination variant writes result to memory
// (RULE5) decrement operand; skip next when zero
// (RULE6) skip takes two instruction cycles
// (RULE7) nonzero result: continue without skipping
// (RULE8) decrement writes memory back, flags untouched
module sbdsk_core
   import sbdsk_pkg::*;
(
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   // core status towards the sequencer
   output logic             busy,
   output logic             instr_done,
   output logic             skip_next
);

   // ------------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------------
   sbdsk_apb_req_t req;          // bundled request lines
   logic        setup_ph;        // apb setup cycle
   logic        wr_fire;         // write takes effect this edge
   logic        hit_ctrl;        // address decodes
   logic        hit_wreg;
   logic        hit_stat;
   logic        hit_maddr;
   logic        hit_mdata;
   logic        mapped;          // any register hit

   logic [31:0] prdata_q;        // registered read data
   logic [31:0] prdata_d;
   logic        pready_q;        // registered ready
   logic        pready_d;
   logic        pslverr_q;       // registered error
   logic        pslverr_d;

   logic [1:0]  div_q;           // instruction-cycle divider
   logic [1:0]  div_d;
   logic        tick;            // one pclk per instruction cycle

   sbdsk_state_t state_q;        // execution sequencer
   sbdsk_state_t state_d;
   sbdsk_op_t    op_q;           // latched opcode
   sbdsk_op_t    op_d;
   logic [5:0]   addr_q;         // latched operand address
   logic [5:0]   addr_d;
   logic [7:0]   work_q;         // work_register
   logic [7:0]   work_d;
   logic [7:0]   stat_q;         // flags and general bits 7:4
   logic [7:0]   stat_d;
   logic         skipped_q;      // sticky skip indication
   logic         skipped_d;
   logic [5:0]   maddr_q;        // software memory pointer
   logic [5:0]   maddr_d;
   logic         busy_q;         // registered outputs
   logic         busy_d;
   logic         done_q;
   logic         done_d;
   logic         skip_q;
   logic         skip_d;

   logic [7:0]   mem_q [DMEM_DEPTH]; // data memory
   logic         mem_we;         // memory write strobe
   logic [5:0]   mem_wa;
   logic [7:0]   mem_wd;

   sbdsk_flags_t flags_cur;      // flags as the alu sees them
   sbdsk_alu_t   alu;            // alu result
   sbdsk_op_t    cmd_op;         // opcode in a control write

   // ------------------------------------------------------------------
   // bus decode
   // ------------------------------------------------------------------
   assign req.addr  = paddr;
   assign req.write = pwrite;
   assign req.wdata = pwdata;
   assign setup_ph  = psel & ~penable;
   // ready is registered, so the access phase always lasts one cycle
   // a refused write changes nothing, even if busy fell meanwhile
   assign wr_fire   = psel & penable & pready_q & req.write &
                      ~pslverr_q;
   assign hit_ctrl  = (req.addr == OFF_CTRL);
   assign hit_wreg  = (req.addr == OFF_WREG);
   assign hit_stat  = (req.addr == OFF_STAT);
   assign hit_maddr = (req.addr == OFF_MADDR);
   assign hit_mdata = (req.addr == OFF_MDATA);
   assign mapped    = hit_ctrl | hit_wreg | hit_stat | hit_maddr |
                      hit_mdata;
   assign cmd_op    = sbdsk_op_t'(req.wdata[CTRL_OP_LSB +: 2]);

   // ------------------------------------------------------------------
   // apb answer: next values
   // ------------------------------------------------------------------
   always_comb begin
      pready_d  = setup_ph;      // answer in the first access cycle
      pslverr_d = 1'b0;
      prdata_d  = 32'h0000_0000;
      if (setup_ph) begin
         // unmapped addresses and writes while busy, except to the pointer, are refused;
         // a refused write changes nothing
         pslverr_d = ~mapped | (req.write & busy_q & ~hit_maddr);
         if (!req.write) begin
            unique case (1'b1)
               hit_ctrl: begin
                  prdata_d[CTRL_OP_LSB +: 2]   = op_q;
                  prdata_d[CTRL_ADDR_LSB +: 6] = addr_q;
               end
               hit_wreg:  prdata_d[7:0] = work_q;
               hit_stat: begin
                  prdata_d[7:0]       = stat_q;
                  prdata_d[STAT_SKIP] = skipped_q;
                  prdata_d[STAT_BUSY] = busy_q;
               end
               hit_maddr: prdata_d[5:0] = maddr_q;
               hit_mdata: prdata_d[7:0] = mem_q[maddr_q];
               default:   prdata_d      = 32'h0000_0000;
            endcase
         end
      end
   end

   // apb answer: registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q  <= prdata_d;
      end
   end

   // ------------------------------------------------------------------
   // instruction-cycle divider
   // ------------------------------------------------------------------
   // free running, so a command waits up to one instruction cycle
   always_comb begin
      tick  = (div_q == INSTR_DIV_LAST);
      div_d = tick ? 2'h0 : div_q + 2'h1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div_q <= 2'h0;
      end else begin
         div_q <= div_d;
      end
   end

   // ------------------------------------------------------------------
   // datapath
   // ------------------------------------------------------------------
   assign flags_cur.signed_wrap_flag = stat_q[STAT_WRAP];
   assign flags_cur.zero_flag        = stat_q[STAT_Z];
   assign flags_cur.half_borrow_flag = stat_q[STAT_HALF];
   assign flags_cur.borrow_flag      = stat_q[STAT_C];

   sbdsk_alu sbdsk_alu_inst (
      .op            (op_q),
      .work_register (work_q),
      .mem_operand   (mem_q[addr_q]),
      .flags_in      (flags_cur),
      .alu_out       (alu)
   );

   // ------------------------------------------------------------------
   // sequencer and architectural state: next values
   // ------------------------------------------------------------------
   always_comb begin
      state_d   = state_q;
      op_d      = op_q;
      addr_d    = addr_q;
      work_d    = work_q;
      stat_d    = stat_q;
      skipped_d = skipped_q;
      maddr_d   = maddr_q;
      done_d    = 1'b0;
      skip_d    = 1'b0;
      mem_we    = 1'b0;
      mem_wa    = maddr_q;
      mem_wd    = req.wdata[7:0];

      // software side; only while idle, except the pointer
      if (wr_fire && hit_maddr) begin
         maddr_d = req.wdata[5:0];
      end
      if (wr_fire && !busy_q) begin
         if (hit_wreg) begin
            work_d = req.wdata[7:0];
         end
         if (hit_stat) begin
            stat_d = req.wdata[7:0];
            // skip indication is write-one-to-clear
            if (req.wdata[STAT_SKIP]) begin
               skipped_d = 1'b0;
            end
         end
         if (hit_mdata) begin
            mem_we = 1'b1;
         end
         if (hit_ctrl && cmd_op != OP_NONE) begin
            op_d    = cmd_op;
            addr_d  = req.wdata[CTRL_ADDR_LSB +: 6];
            state_d = ST_EXEC;
         end
      end

      unique case (state_q)
         ST_IDLE: begin
            // commands are picked up by the bus branch above
         end
         ST_EXEC: begin
            if (tick) begin
               unique case (op_q)
                  OP_SUBTRACT_WITH_BORROW: begin
                     work_d = alu.result;                     // [RULE1]
                  end
                  OP_SUBTRACT_BORROW_TO_MEMORY: begin
                     mem_we = 1'b1;                           // [RULE4]
                     mem_wa = addr_q;
                     mem_wd = alu.result;
                  end
                  OP_DECREMENT_SKIP_IF_NULL: begin
                     mem_we = 1'b1;                           // [RULE8]
                     mem_wa = addr_q;
                     mem_wd = alu.result;
                  end
                  default: begin
                  end
               endcase
               if (op_q != OP_DECREMENT_SKIP_IF_NULL) begin
                  // only the four flags move; bits 7:4 stay
                  stat_d[STAT_C]    = alu.flags.borrow_flag;      // [RULE2]
                  stat_d[STAT_HALF] = alu.flags.half_borrow_flag; // [RULE3]
                  stat_d[STAT_Z]    = alu.flags.zero_flag;        // [RULE3]
                  stat_d[STAT_WRAP] = alu.flags.signed_wrap_flag; // [RULE3]
               end
               if (op_q == OP_DECREMENT_SKIP_IF_NULL && alu.is_zero) begin
                  state_d = ST_DUMMY;                         // [RULE6]
               end else begin
                  state_d = ST_IDLE;                          // [RULE7]
                  done_d  = 1'b1;
               end
            end
         end
         ST_DUMMY: begin
            // second instruction cycle; next instruction is discarded
            if (tick) begin
               state_d   = ST_IDLE;                           // [RULE6]
               done_d    = 1'b1;
               skip_d    = 1'b1;                              // [RULE5]
               skipped_d = 1'b1;  // set placed after clear: set wins
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
      busy_d = (state_d != ST_IDLE);
   end

   // sequencer and architectural state: registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q   <= ST_IDLE;
         op_q      <= OP_NONE;
         addr_q    <= 6'h00;
         work_q    <= WREG_RST;
         stat_q    <= STAT_RST;
         skipped_q <= 1'b0;
         maddr_q   <= MADDR_RST;
         busy_q    <= 1'b0;
         done_q    <= 1'b0;
         skip_q    <= 1'b0;
      end else begin
         state_q   <= state_d;
         op_q      <= op_d;
         addr_q    <= addr_d;
         work_q    <= work_d;
         stat_q    <= stat_d;
         skipped_q <= skipped_d;
         maddr_q   <= maddr_d;
         busy_q    <= busy_d;
         done_q    <= done_d;
         skip_q    <= skip_d;
      end
   end

   // ------------------------------------------------------------------
   // data memory
   // ------------------------------------------------------------------
   // no reset: contents are undefined until software loads them
   always_ff @(posedge pclk) begin
      if (mem_we) begin
         mem_q[mem_wa] <= mem_wd;
      end
   end

   // ------------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------------
   assign prdata     = prdata_q;
   assign pready     = pready_q;
   assign pslverr    = pslverr_q;
   assign busy       = busy_q;
   assign instr_done = done_q;
   assign skip_next  = skip_q;

endmodule

//--- design/sbdsk_pkg.sv
// ---------------------------------------------------------------------
// shared constants and types for the subtract / decrement-skip block
// ---------------------------------------------------------------------
package sbdsk_pkg;

   // ------------------------------------------------------------------
   // register offsets (byte addresses on the apb bus)
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_CTRL  = 8'h00; // command and operand address
   localparam logic [7:0] OFF_WREG  = 8'h04; // work register
   localparam logic [7:0] OFF_STAT  = 8'h08; // status flags
   localparam logic [7:0] OFF_MADDR = 8'h0C; // data memory pointer
   localparam logic [7:0] OFF_MDATA = 8'h10; // data memory window

   // ------------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------------
   localparam int CTRL_OP_LSB   = 0;  // two-bit opcode
   localparam int CTRL_ADDR_LSB = 8;  // six-bit operand address
   localparam int STAT_C        = 0;  // borrow flag (1 = no borrow)
   localparam int STAT_HALF     = 1;  // half_borrow_flag
   localparam int STAT_Z        = 2;  // zero-result flag
   localparam int STAT_WRAP     = 3;  // signed_wrap_flag
   localparam int STAT_SKIP     = 8;  // sticky: last instruction skipped
   localparam int STAT_BUSY     = 9;  // instruction in progress

   // ------------------------------------------------------------------
   // reset values and sizes
   // ------------------------------------------------------------------
   localparam logic [7:0] WREG_RST  = 8'h00;
   localparam logic [7:0] STAT_RST  = 8'h00;
   localparam logic [5:0] MADDR_RST = 6'h00;
   localparam int         DMEM_AW   = 6;
   localparam int         DMEM_DEPTH = 64;

   // ------------------------------------------------------------------
   // timing: pclk cycles per instruction cycle
   // ------------------------------------------------------------------
   localparam logic [1:0] INSTR_DIV_LAST = 2'h3; // divide by four

   // ------------------------------------------------------------------
   // types
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      OP_NONE                      = 2'b00,
      OP_SUBTRACT_WITH_BORROW      = 2'b01,
      OP_SUBTRACT_BORROW_TO_MEMORY = 2'b10,
      OP_DECREMENT_SKIP_IF_NULL    = 2'b11
   } sbdsk_op_t;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,  // waiting for a command
      ST_EXEC  = 2'b01,  // waiting for the instruction-cycle tick
      ST_DUMMY = 2'b10   // dummy cycle of a skip
   } sbdsk_state_t;

   typedef struct packed {
      logic signed_wrap_flag;
      logic zero_flag;
      logic half_borrow_flag;
      logic borrow_flag;
   } sbdsk_flags_t;

   typedef struct packed {
      logic [7:0]   result;
      sbdsk_flags_t flags;
      logic         is_zero;
   } sbdsk_alu_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic        write;
      logic [31:0] wdata;
   } sbdsk_apb_req_t;

endpackage

//--- design/sbdsk_alu.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// combinational datapath: subtract with borrow and decrement
// ---------------------------------------------------------------------
module sbdsk_alu
   import sbdsk_pkg::*;
(
   // operation select
   input  wire sbdsk_op_t    op,
   // operands
   input  wire logic [7:0]   work_register,
   input  wire logic [7:0]   mem_operand,
   input  wire sbdsk_flags_t flags_in,
   // result and new flags
   output sbdsk_alu_t        alu_out
);

   // difference with borrow-in; msb of the result is the borrow out
   function automatic logic [8:0] sub_borrow(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic       bin);
      sub_borrow = {1'b0, a} - {1'b0, b} - {8'h00, bin};
   endfunction

   logic [8:0] full_d;   // nine-bit difference
   logic [8:0] nib_d;    // low-nibble difference
   logic       bin;      // borrow-in is the inverse of the borrow flag

   // -------------------------------------------------------------------
   // result and flags
   // -------------------------------------------------------------------
   always_comb begin
      bin     = ~flags_in.borrow_flag;
      full_d  = sub_borrow(work_register, mem_operand, bin);  // [RULE1]
      nib_d   = sub_borrow({4'h0, work_register[3:0]},
                           {4'h0, mem_operand[3:0]}, bin);
      alu_out = '0;
      alu_out.flags = flags_in;
      if (op == OP_DECREMENT_SKIP_IF_NULL) begin
         // flags stay as they were
         alu_out.result = mem_operand - 8'h01;               // [RULE5]
      end else begin
         alu_out.result = full_d[7:0];
         // borrow flag: 0 on negative, 1 on zero or positive
         alu_out.flags.borrow_flag      = ~full_d[8];        // [RULE2]
         alu_out.flags.half_borrow_flag = ~nib_d[4];         // [RULE3]
         alu_out.flags.zero_flag        = (full_d[7:0] == 8'h00);
         alu_out.flags.signed_wrap_flag =
            (work_register[7] ^ mem_operand[7]) &
            (work_register[7] ^ full_d[7]);                  // [RULE3]
      end
      alu_out.is_zero = (alu_out.result == 8'h00);
   end

endmodule

//--- tb/sbdsk_core_sva.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------
// port-level checker for the subtract / decrement-skip unit
// ---------------------------------------------------------------------
module sbdsk_core_sva
   import sbdsk_pkg::*;
(
   // clock and reset
   input wire logic        pclk,
   input wire logic        presetn,
   // apb slave side
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // sequencer status
   input wire logic        busy,
   input wire logic        instr_done,
   input wire logic        skip_next
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ------------------------------------------------------------------
   // helper: an accepted command write
   // ------------------------------------------------------------------
   logic cmd_go; // ctrl write with a real opcode, not refused
   assign cmd_go = psel && penable && pwrite && pready && !pslverr
                   && (paddr == OFF_CTRL) && (pwdata[1:0] != 2'b00);

   // ------------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------------
   access_ready_a: assert property (psel && !penable |=> pready)
      else $error("no ready in the access cycle");
   ready_cause_a: assert property (pready |-> psel && penable
                                   && $past(psel && !penable))
      else $error("ready outside an access cycle");
   err_with_ready_a: assert property (pslverr |-> pready)
      else $error("error flag without ready");
   // read data must not leak outside a read access
   idle_rdata_a: assert property ((!pready || pwrite) |-> prdata == 32'h0)
      else $error("read data not zero outside a read");

   // ------------------------------------------------------------------
   // instruction sequencing
   // ------------------------------------------------------------------
   cmd_busy_a: assert property (cmd_go |=> busy)
      else $error("accepted command did not raise busy");
   // skip path is the longest: tick wait plus one dummy instruction cycle
   done_bound_a: assert property (
      $rose(busy) |-> ##[1:12] instr_done)
      else $error("instruction did not finish in time");
   busy_until_done_a: assert property (
      instr_done |-> !busy && $past(busy))
      else $error("done pulse not at the end of busy");
   done_pulse_a: assert property (instr_done |=> !instr_done)
      else $error("done pulse longer than one cycle");
   skip_with_done_a: assert property (skip_next |-> instr_done)
      else $error("skip pulse without done");
   skip_dummy_a: assert property (skip_next |-> $past(busy, 4))
      else $error("skip finished without a dummy cycle");

   // ------------------------------------------------------------------
   // scenario coverage
   // ------------------------------------------------------------------
   cover property (skip_next);
   cover property (instr_done && !skip_next);
   cover property (pslverr);
endmodule

bind sbdsk_core sbdsk_core_sva sbdsk_core_sva_inst (
   .pclk       (pclk),
   .presetn    (presetn),
   .psel       (psel),
   .penable    (penable),
   .pwrite     (pwrite),
   .paddr      (paddr),
   .pwdata     (pwdata),
   .prdata     (prdata),
   .pready     (pready),
   .pslverr    (pslverr),
   .busy       (busy),
   .instr_done (instr_done),
   .skip_next  (skip_next)
);

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
   import sbdsk_pkg::*;

   // ------------------------------------------------------------------
   // signals and bookkeeping
   // ------------------------------------------------------------------
   logic        pclk, presetn, psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd;
   logic        pready, pslverr, busy, instr_done, skip_next, er, sk;
   int          error_cnt, tests_run, cyc;
   // subtract vectors: work value, memory value, borrow flag in
   logic [7:0]  vw [6] = '{8'h50, 8'h20, 8'h80, 8'h10, 8'h00, 8'h05};
   logic [7:0]  vm [6] = '{8'h20, 8'h50, 8'h01, 8'h01, 8'h00, 8'h04};
   logic        vc [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
   // decrement operands: hits zero, wraps, plain
   logic [7:0]  dv [3] = '{8'h01, 8'h00, 8'h10};

   sbdsk_core sbdsk_core_inst (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .busy(busy),
      .instr_done(instr_done), .skip_next(skip_next)
   );

   // ------------------------------------------------------------------
   // clock and hang guard
   // ------------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // whole run needs well under a thousand cycles; 20000 means a hang
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // ------------------------------------------------------------------
   // tasks
   // ------------------------------------------------------------------
   task automatic print_verdict();
      if (error_cnt == 0 && tests_run > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, got);
      tests_run++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // one apb transfer; leaves read data in rd and the error flag in er
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge pclk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // wait for the answer; only the bench timeout ends a hang
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic mem_set(input logic [5:0] a, input logic [7:0] v);
      apb(1'b1, OFF_MADDR, {26'h0, a});
      apb(1'b1, OFF_MDATA, {24'h0, v});
   endtask

   task automatic mem_get(input logic [5:0] a);
      apb(1'b1, OFF_MADDR, {26'h0, a});
      apb(1'b0, OFF_MDATA, 32'h0);
   endtask

   // wait for the done pulse, note whether it came with a skip
   task automatic wait_done();
      int n;
      n = 0;
      sk = 1'b0;
      while (instr_done !== 1'b1 && n < 20) begin
         @(posedge pclk);
         n++;
      end
      sk = skip_next;
      chk("done_seen", 32'h1, {31'h0, instr_done});
      chk("busy_end", 32'h0, {31'h0, busy});
   endtask

   task automatic run(input sbdsk_op_t op, input logic [5:0] a);
      apb(1'b1, OFF_CTRL, {18'h0, a, 6'h0, op});
      chk("ctrl_err", 32'h0, {31'h0, er});
      wait_done();
   endtask

   function automatic logic [11:0] sub_ref(input logic [7:0] w, m,
                                           input logic c);
      logic [8:0] f;
      logic [4:0] h;
      f = {1'b0, w} - {1'b0, m} - {8'h0, ~c};
      h = {1'b0, w[3:0]} - {1'b0, m[3:0]} - {4'h0, ~c};
      return {f[7:0], (w[7] ^ m[7]) & (w[7] ^ f[7]), f[7:0] == 8'h00,
              ~h[4], ~f[8]};
   endfunction

   // ------------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------------
   initial begin
      logic [11:0] e;
      logic [5:0]  ad;
      psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
      paddr = 8'h00; pwdata = 32'h0; presetn = 1'b0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFF_WREG, 32'h0);
      chk("wreg_rst", {24'h0, WREG_RST}, rd);
      apb(1'b0, OFF_STAT, 32'h0);
      chk("stat_rst", {24'h0, STAT_RST}, rd);
      // both subtract variants; borrow flag preset to the borrow in, the other three flags to the inverse of the answer
      for (int o = 0; o < 2; o++) begin
         for (int i = 0; i < 6; i++) begin
            e  = sub_ref(vw[i], vm[i], vc[i]);
            ad = 6'(i * 9);
            mem_set(ad, vm[i]);
            apb(1'b1, OFF_WREG, {24'h0, vw[i]});
            apb(1'b1, OFF_STAT, {24'h0, 4'hA, ~e[3:1], vc[i]});
            run(o ? OP_SUBTRACT_BORROW_TO_MEMORY
                  : OP_SUBTRACT_WITH_BORROW, ad);
            chk("sub_skip", 32'h0, {31'h0, sk});
            apb(1'b0, OFF_WREG, 32'h0);
            chk("sub_wreg", {24'h0, o ? vw[i] : e[11:4]}, rd);
            apb(1'b0, OFF_STAT, 32'h0);
            chk("sub_stat", {24'h0, 4'hA, e[3:0]}, rd);
            mem_get(ad);
            chk("sub_mem", {24'h0, o ? e[11:4] : vm[i]}, rd);
         end
      end
      // decrement-and-skip at the top memory address
      for (int i = 0; i < 3; i++) begin
         mem_set(6'h3F, dv[i]);
         apb(1'b1, OFF_STAT, 32'h0000005B);
         run(OP_DECREMENT_SKIP_IF_NULL, 6'h3F);
         chk("dec_skip", 32'(dv[i] == 8'h01), 32'(sk));
         mem_get(6'h3F);
         chk("dec_mem", {24'h0, dv[i] - 8'h01}, rd);
         apb(1'b0, OFF_STAT, 32'h0);
         chk("dec_stat", {23'h0, dv[i] == 8'h01, 8'h5B}, rd);
         apb(1'b1, OFF_STAT, 32'h0000015B);
      end
      apb(1'b0, OFF_WREG, 32'h0);
      chk("dec_wreg", {24'h0, vw[5]}, rd);
      // a skipping command is long enough to be hit while busy
      mem_set(6'h3F, 8'h01);
      apb(1'b1, OFF_WREG, 32'h00000033);
      apb(1'b1, OFF_CTRL, {18'h0, 6'h3F, 6'h0, OP_DECREMENT_SKIP_IF_NULL});
      apb(1'b1, OFF_WREG, 32'h000000CC);
      chk("busy_err", 32'h1, {31'h0, er});
      chk("busy_out", 32'h1, {31'h0, busy});
      apb(1'b0, OFF_STAT, 32'h0);
      chk("busy_stat", 32'h0000025B, rd);
      wait_done();
      chk("busy_skip", 32'h1, {31'h0, sk});
      apb(1'b0, OFF_WREG, 32'h0);
      chk("busy_wreg", 32'h00000033, rd);
      // unmapped offset
      apb(1'b0, 8'h14, 32'h0);
      chk("unmapped_err", 32'h1, {31'h0, er});
      chk("unmapped_rd", 32'h0, rd);
      // opcode zero starts nothing; control reads back the last command
      apb(1'b1, OFF_CTRL, 32'h00000000);
      apb(1'b0, OFF_CTRL, 32'h0);
      chk("ctrl_rd", 32'h00003F03, rd);
      chk("none_busy", 32'h0, {31'h0, busy});
      print_verdict();
   end
endmodule
